/* File: shared/lpmsc_consts.vh */
`ifndef LPMSC_CONSTS_VH
`define LPMSC_CONSTS_VH
`define LPMSC_AW 8
`define LPMSC_OFF_LPC 8'h00
`define LPMSC_OFF_MSA 8'h04
`define LPMSC_OFF_MSB 8'h08
`define LPMSC_OFF_MSC 8'h0C
`define LPMSC_OFF_SBY 8'h10
`define LPMSC_OFF_MODE 8'h14
`define LPMSC_NREG 5
`define LPMSC_IDX_LPC 0
`define LPMSC_IDX_MSA 1
`define LPMSC_IDX_MSB 2
`define LPMSC_IDX_MSC 3
`define LPMSC_IDX_SBY 4
`define LPMSC_RST_LPC 8'h00
`define LPMSC_RST_MSA 8'h3F
`define LPMSC_RST_MSB 8'hFF
`define LPMSC_RST_MSC 8'hFF
`define LPMSC_RST_SBY 8'h00
`define LPMSC_BIT_DIRECT 7
`define LPMSC_BIT_LOW_SPEED 6
`define LPMSC_BIT_SUBCLK_STOP 4
`define LPMSC_BIT_FB_CUT 3
`define LPMSC_BIT_STC_HI 1
`define LPMSC_BIT_STC_LO 0
`define LPMSC_BIT_SBY_SEL 0
`define LPMSC_BIT_TIMER 5
`define LPMSC_BIT_ADC 1
`define LPMSC_BIT_SER0 7
`define LPMSC_BIT_SER1 6
`define LPMSC_BIT_SER2 5
`define LPMSC_BIT_CAN 3
`define LPMSC_MODE_HIGH 3'h0
`define LPMSC_MODE_MEDIUM 3'h1
`define LPMSC_MODE_SUBACT 3'h2
`define LPMSC_MODE_SLEEP 3'h3
`define LPMSC_MODE_SUBSLP 3'h4
`define LPMSC_MODE_STBY 3'h5
`define LPMSC_MODE_WATCH 3'h6
`define LPMSC_RESP_OKAY 2'h0
`define LPMSC_RESP_SLVERR 2'h2
`endif

/* File: rtl/lpmsc_top.v */
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "lpmsc_consts.vh"
module lpmsc_top (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire sleep_exec,
  input wire wake_event,
  input wire medium_speed_req,
  output wire [2:0] power_mode,
  output wire subclock_enable,
  output wire main_osc_run,
  output wire feedback_resistor_on,
  output wire [1:0] pll_factor,
  output wire timer_unit_stop,
  output wire adc_stop,
  output wire serial0_stop,
  output wire serial1_stop,
  output wire serial2_stop,
  output wire can_stop
);

  localparam NREG = `LPMSC_NREG;
  localparam [2:0] ST_HIGH = `LPMSC_MODE_HIGH;
  localparam [2:0] ST_MEDIUM = `LPMSC_MODE_MEDIUM;
  localparam [2:0] ST_SUBACT = `LPMSC_MODE_SUBACT;
  localparam [2:0] ST_SLEEP = `LPMSC_MODE_SLEEP;
  localparam [2:0] ST_SUBSLP = `LPMSC_MODE_SUBSLP;
  localparam [2:0] ST_STBY = `LPMSC_MODE_STBY;
  localparam [2:0] ST_WATCH = `LPMSC_MODE_WATCH;

  // Reset value and offset of each stored register, packed per index
  localparam [8*NREG-1:0] RST_VEC = {`LPMSC_RST_SBY, `LPMSC_RST_MSC,
    `LPMSC_RST_MSB, `LPMSC_RST_MSA, `LPMSC_RST_LPC};
  localparam [8*NREG-1:0] OFF_VEC = {`LPMSC_OFF_SBY, `LPMSC_OFF_MSC,
    `LPMSC_OFF_MSB, `LPMSC_OFF_MSA, `LPMSC_OFF_LPC};

  // Write channel state
  reg awready_ff;
  reg wready_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg aw_got_ff;
  reg w_got_ff;
  reg [7:0] waddr_ff;
  reg [7:0] wbyte_ff;
  reg wlane_ff;
  reg nxt_aw_got;
  reg nxt_w_got;
  reg nxt_bvalid;

  // Read channel state
  reg arready_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg [7:0] rd_byte;
  reg rd_hit;

  // Control registers and mode machine
  reg [7:0] creg_ff [0:NREG-1];
  reg [2:0] mode_ff;
  reg [2:0] nxt_mode;
  reg [2:0] ret_mode_ff;
  reg [2:0] nxt_ret_mode;
  reg cut_applied_ff;
  reg osc_run_ff;
  reg fb_on_ff;
  reg subclk_en_ff;
  reg [1:0] pll_ff;

  wire aw_ok;
  wire w_ok;
  wire do_write;
  wire ar_ok;
  wire [NREG-1:0] wr_sel;
  wire wr_hit;
  wire [7:0] lpc;
  wire standby_select_bit;
  wire direct_transition_flag;
  wire low_speed_flag;
  wire active_mode;
  wire osc_mode;
  wire enter_stby;
  wire leave_stby;

  assign aw_ok = s_axi_awvalid & awready_ff;
  assign w_ok = s_axi_wvalid & wready_ff;
  // Address and data may arrive in either order; both must be held
  assign do_write = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign ar_ok = s_axi_arvalid & arready_ff;

  assign lpc = creg_ff[`LPMSC_IDX_LPC];
  assign standby_select_bit = creg_ff[`LPMSC_IDX_SBY][`LPMSC_BIT_SBY_SEL];
  assign direct_transition_flag = lpc[`LPMSC_BIT_DIRECT];
  assign low_speed_flag = lpc[`LPMSC_BIT_LOW_SPEED];

  always @* begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_bvalid = bvalid_ff;
    if (aw_ok) begin
      nxt_aw_got = 1'b1;
    end
    if (w_ok) begin
      nxt_w_got = 1'b1;
    end
    if (do_write) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff <= ~nxt_w_got & ~nxt_bvalid;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      waddr_ff <= 8'h00;
    end else if (aw_ok) begin
      waddr_ff <= {s_axi_awaddr[7:2], 2'b00};
    end
  end

  // Registers are 8 bits in byte lane 0; other lanes are dropped
  always @(posedge aclk) begin
    if (!aresetn) begin
      wbyte_ff <= 8'h00;
      wlane_ff <= 1'b0;
    end else if (w_ok) begin
      wbyte_ff <= s_axi_wdata[7:0];
      wlane_ff <= s_axi_wstrb[0];
    end
  end

  assign wr_hit = |wr_sel | (waddr_ff == `LPMSC_OFF_MODE);

  always @(posedge aclk) begin
    if (!aresetn) begin
      bresp_ff <= `LPMSC_RESP_OKAY;
    end else if (do_write) begin
      bresp_ff <= wr_hit ? `LPMSC_RESP_OKAY : `LPMSC_RESP_SLVERR;
    end
  end

  // Every bit is kept as written, reserved ones included
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
      assign wr_sel[gi] = (waddr_ff == OFF_VEC[8*gi +: 8]);
      always @(posedge aclk) begin
        if (!aresetn) begin
          creg_ff[gi] <= RST_VEC[8*gi +: 8];
        end else if (do_write && wr_sel[gi] && wlane_ff) begin
          creg_ff[gi] <= wbyte_ff;
        end
      end
    end
  endgenerate

  // Read path
  always @* begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `LPMSC_OFF_LPC: rd_byte = creg_ff[`LPMSC_IDX_LPC];
      `LPMSC_OFF_MSA: rd_byte = creg_ff[`LPMSC_IDX_MSA];
      `LPMSC_OFF_MSB: rd_byte = creg_ff[`LPMSC_IDX_MSB];
      `LPMSC_OFF_MSC: rd_byte = creg_ff[`LPMSC_IDX_MSC];
      `LPMSC_OFF_SBY: rd_byte = creg_ff[`LPMSC_IDX_SBY];
      `LPMSC_OFF_MODE: rd_byte = {3'b000, osc_run_ff, cut_applied_ff,
        mode_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `LPMSC_RESP_OKAY;
    end else if (ar_ok) begin
      rvalid_ff <= 1'b1;
      arready_ff <= 1'b0;
      rdata_ff <= {24'h000000, rd_byte};
      rresp_ff <= rd_hit ? `LPMSC_RESP_OKAY : `LPMSC_RESP_SLVERR;
    end else if (rvalid_ff) begin
      if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end else begin
      arready_ff <= 1'b1;
    end
  end

  assign active_mode = (mode_ff == ST_HIGH) || (mode_ff == ST_MEDIUM);

  // Sleep targets are resolved from flags as they stand at the sleep; a watch exit uses the low-speed flag at the wake
  always @* begin
    nxt_mode = mode_ff;
    nxt_ret_mode = ret_mode_ff;
    case (mode_ff)
      ST_HIGH, ST_MEDIUM: begin
        if (sleep_exec) begin
          nxt_ret_mode = mode_ff;
          if (!standby_select_bit) begin
            nxt_mode = ST_SLEEP;
          end else if (!low_speed_flag) begin
            nxt_mode = ST_STBY;
          end else if (mode_ff == ST_MEDIUM) begin
            // Watch and subactive need high speed; stay safe in standby
            nxt_mode = ST_STBY;
          end else if (direct_transition_flag) begin
            nxt_mode = ST_SUBACT;
          end else begin
            nxt_mode = ST_WATCH;
          end
        end else if (medium_speed_req) begin
          nxt_mode = ST_MEDIUM;
        end else begin
          nxt_mode = ST_HIGH;
        end
      end
      ST_SUBACT: begin
        if (sleep_exec) begin
          nxt_ret_mode = ST_SUBACT;
          if (!standby_select_bit) begin
            nxt_mode = ST_SUBSLP;
          end else if (direct_transition_flag && !low_speed_flag) begin
            nxt_mode = ST_HIGH;
          end else begin
            nxt_mode = ST_WATCH;
          end
        end
      end
      ST_SLEEP: begin
        if (wake_event) begin
          nxt_mode = ret_mode_ff;
        end
      end
      ST_SUBSLP: begin
        if (wake_event) begin
          nxt_mode = ST_SUBACT;
        end
      end
      ST_STBY: begin
        if (wake_event) begin
          nxt_mode = ret_mode_ff;
        end
      end
      ST_WATCH: begin
        if (wake_event) begin
          nxt_mode = low_speed_flag ? ST_SUBACT : ST_HIGH;
        end
      end
      default: begin
        nxt_mode = ST_HIGH;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= ST_HIGH;
      ret_mode_ff <= ST_HIGH;
    end else begin
      mode_ff <= nxt_mode;
      ret_mode_ff <= nxt_ret_mode;
    end
  end

  // Main oscillator stops in standby, watch and the subclock modes
  assign osc_mode = (nxt_mode == ST_HIGH) || (nxt_mode == ST_MEDIUM) ||
    (nxt_mode == ST_SLEEP);

  assign enter_stby = (nxt_mode == ST_STBY) && (mode_ff != ST_STBY);
  assign leave_stby = (nxt_mode != ST_STBY) && (mode_ff == ST_STBY);

  // A changed cut setting is deferred so a running crystal is not killed
  always @(posedge aclk) begin
    if (!aresetn) begin
      cut_applied_ff <= 1'b0;
    end else if (enter_stby || leave_stby) begin
      cut_applied_ff <= lpc[`LPMSC_BIT_FB_CUT];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_run_ff <= 1'b1;
      fb_on_ff <= 1'b1;
    end else begin
      osc_run_ff <= osc_mode;
      fb_on_ff <= osc_mode & ~cut_applied_ff;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      subclk_en_ff <= 1'b1;
    end else begin
      subclk_en_ff <= ~lpc[`LPMSC_BIT_SUBCLK_STOP];
    end
  end

  // The prohibited code is passed on as written; software must avoid it
  always @(posedge aclk) begin
    if (!aresetn) begin
      pll_ff <= 2'b00;
    end else begin
      pll_ff <= {lpc[`LPMSC_BIT_STC_HI], lpc[`LPMSC_BIT_STC_LO]};
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign power_mode = mode_ff;
  assign subclock_enable = subclk_en_ff;
  assign main_osc_run = osc_run_ff;
  assign feedback_resistor_on = fb_on_ff;
  assign pll_factor = pll_ff;
  // Stop outputs are the register bits themselves
  assign timer_unit_stop = creg_ff[`LPMSC_IDX_MSA][`LPMSC_BIT_TIMER];
  assign adc_stop = creg_ff[`LPMSC_IDX_MSA][`LPMSC_BIT_ADC];
  assign serial0_stop = creg_ff[`LPMSC_IDX_MSB][`LPMSC_BIT_SER0];
  assign serial1_stop = creg_ff[`LPMSC_IDX_MSB][`LPMSC_BIT_SER1];
  assign serial2_stop = creg_ff[`LPMSC_IDX_MSB][`LPMSC_BIT_SER2];
  assign can_stop = creg_ff[`LPMSC_IDX_MSC][`LPMSC_BIT_CAN];

endmodule // lpmsc_top
`default_nettype wire

/* File: bench/lpmsc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpmsc_consts.vh"
module lpmsc_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic sleep_exec,
  input wire logic wake_event,
  input wire logic [2:0] power_mode,
  input wire logic main_osc_run,
  input wire logic feedback_resistor_on,
  input wire logic timer_unit_stop,
  input wire logic serial0_stop,
  input wire logic can_stop
);
  default clocking mon_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic osc_mode = power_mode == `LPMSC_MODE_HIGH ||
    power_mode == `LPMSC_MODE_MEDIUM || power_mode == `LPMSC_MODE_SLEEP;
  // Subactive runs on the subclock, so it is neither oscillating nor low
  wire logic low_mode = !osc_mode && power_mode != `LPMSC_MODE_SUBACT;
  wire logic [2:0] stops = {timer_unit_stop, serial0_stop, can_stop};
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sleep_in(logic [2:0] m);
    sleep_exec && power_mode == m;
  endsequence
  // Register is written the cycle after the take, with the response
  wr_answer_a: assert property (wr_take |=> ##1 s_axi_bvalid)
    else $error("write not answered two cycles after take");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered one cycle after take");
  // Stop bits are the registers, so they only move with a write response
  stop_write_a: assert property ($past(aresetn) && !$stable(stops) |->
    $rose(s_axi_bvalid)) else $error("stop output moved without a write");
  sleep_high_a: assert property (sleep_in(`LPMSC_MODE_HIGH) |=>
    power_mode inside {`LPMSC_MODE_SLEEP, `LPMSC_MODE_STBY,
    `LPMSC_MODE_SUBACT, `LPMSC_MODE_WATCH}) else $error("bad target");
  sleep_sub_a: assert property (sleep_in(`LPMSC_MODE_SUBACT) |=>
    power_mode inside {`LPMSC_MODE_SUBSLP, `LPMSC_MODE_WATCH,
    `LPMSC_MODE_HIGH}) else $error("bad target from subactive");
  watch_exit_a: assert property (wake_event &&
    power_mode == `LPMSC_MODE_WATCH |=> power_mode inside
    {`LPMSC_MODE_SUBACT, `LPMSC_MODE_HIGH}) else $error("bad watch exit");
  low_hold_a: assert property (low_mode && !wake_event |=>
    $stable(power_mode)) else $error("low-power mode left without wake");
  osc_follow_a: assert property ($past(aresetn) |->
    main_osc_run == osc_mode) else $error("oscillator run wrong");
  fb_off_a: assert property (!main_osc_run |->
    !feedback_resistor_on) else $error("resistor on with clock stopped");
endmodule // lpmsc_monitor
bind lpmsc_top lpmsc_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .sleep_exec, .wake_event,
  .power_mode, .main_osc_run, .feedback_resistor_on, .timer_unit_stop,
  .serial0_stop, .can_stop);
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpmsc_consts.vh"
module tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, sleep_exec = 1'h0;
  logic wake_event = 1'h0, medium_speed_req = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  wire [31:0] s_axi_rdata;
  wire [1:0] s_axi_bresp, s_axi_rresp, pll_factor;
  wire [2:0] power_mode;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, subclock_enable, main_osc_run, feedback_resistor_on;
  wire timer_unit_stop, adc_stop, serial0_stop, serial1_stop;
  wire serial2_stop, can_stop;
  wire [5:0] stops = {timer_unit_stop, adc_stop, serial0_stop,
    serial1_stop, serial2_stop, can_stop};
  int err_total = 0, total_checks = 0;
  lpmsc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sleep_exec, .wake_event, .medium_speed_req, .power_mode,
    .subclock_enable, .main_osc_run, .feedback_resistor_on, .pll_factor,
    .timer_unit_stop, .adc_stop, .serial0_stop, .serial1_stop,
    .serial2_stop, .can_stop);
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task timed_out;
    err_total++;
    report_and_stop;
  endtask
  // Address and data go out together and drop independently when taken
  task axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int n;
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (n = 0; n < 20 && !(ad && wd); n++) begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    if (!(ad && wd)) timed_out;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 20 && !s_axi_bvalid; n++) @(posedge aclk);
    if (!s_axi_bvalid) timed_out;
    check(s_axi_bresp, er);
    s_axi_bready <= 1'h0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 20 && !(s_axi_arvalid && s_axi_arready); n++)
      @(posedge aclk);
    if (!(s_axi_arvalid && s_axi_arready)) timed_out;
    s_axi_arvalid <= 1'h0;
    for (n = 0; n < 20 && !s_axi_rvalid; n++) @(posedge aclk);
    if (!s_axi_rvalid) timed_out;
    check(s_axi_rresp, er);
    check(s_axi_rdata, e);
    // Ready is left up after the read; the next read drives it high again
  endtask
  task t_reset;
    rd_chk(`LPMSC_OFF_LPC, 32'h0, `LPMSC_RESP_OKAY);
    rd_chk(`LPMSC_OFF_MSA, 32'h3F, `LPMSC_RESP_OKAY);
    rd_chk(`LPMSC_OFF_MSB, 32'hFF, `LPMSC_RESP_OKAY);
    rd_chk(`LPMSC_OFF_MSC, 32'hFF, `LPMSC_RESP_OKAY);
    check(stops, 32'h3F);
    $display("reset test done");
  endtask
  task t_stops;
    axi_wr(`LPMSC_OFF_MSA, 32'h1D, `LPMSC_RESP_OKAY);
    axi_wr(`LPMSC_OFF_MSB, 32'h1F, `LPMSC_RESP_OKAY);
    axi_wr(`LPMSC_OFF_MSC, 32'hF7, `LPMSC_RESP_OKAY);
    check(stops, 32'h0);
    rd_chk(`LPMSC_OFF_MSA, 32'h1D, `LPMSC_RESP_OKAY);
    axi_wr(`LPMSC_OFF_MSB, 32'h5F, `LPMSC_RESP_OKAY);
    check(stops, 32'h04);
    // Unmapped word: refused, and MSB keeps its contents
    axi_wr(8'h18, 32'h0, `LPMSC_RESP_SLVERR);
    rd_chk(8'h18, 32'h0, `LPMSC_RESP_SLVERR);
    rd_chk(`LPMSC_OFF_MSB, 32'h5F, `LPMSC_RESP_OKAY);
    $display("module stop test done");
  endtask
  task t_lpc;
    int i;
    logic [31:0] v;
    for (i = 0; i < 4; i++) begin
      v = {27'h0, i[0], 2'h0, i[1:0] % 2'h3};
      axi_wr(`LPMSC_OFF_LPC, v, `LPMSC_RESP_OKAY);
      @(posedge aclk);
      check(pll_factor, v[1:0]);
      check(subclock_enable, !v[4]);
      rd_chk(`LPMSC_OFF_LPC, v, `LPMSC_RESP_OKAY);
    end
    $display("low power control test done");
  endtask
  // Program flags, fire one sleep or wake pulse, judge the new mode
  task step(input logic sby, input logic [7:0] lpc, input logic wk,
      input logic [2:0] em, input logic cut);
    logic osc;
    axi_wr(`LPMSC_OFF_SBY, {31'h0, sby}, `LPMSC_RESP_OKAY);
    axi_wr(`LPMSC_OFF_LPC, {24'h0, lpc}, `LPMSC_RESP_OKAY);
    if (wk) wake_event <= 1'h1;
    else sleep_exec <= 1'h1;
    @(posedge aclk);
    wake_event <= 1'h0;
    sleep_exec <= 1'h0;
    // Resistor follows the applied cut one cycle after the mode moves
    @(posedge aclk);
    @(posedge aclk);
    osc = em inside {`LPMSC_MODE_HIGH, `LPMSC_MODE_MEDIUM, `LPMSC_MODE_SLEEP};
    check(power_mode, em);
    check(main_osc_run, osc);
    check(feedback_resistor_on, osc & !cut);
  endtask
  task t_modes;
    int n;
    step(1'h0, 8'h00, 1'h0, `LPMSC_MODE_SLEEP, 1'h0);
    step(1'h0, 8'h00, 1'h1, `LPMSC_MODE_HIGH, 1'h0);
    step(1'h1, 8'h00, 1'h0, `LPMSC_MODE_STBY, 1'h0);
    step(1'h1, 8'h00, 1'h1, `LPMSC_MODE_HIGH, 1'h0);
    step(1'h1, 8'h40, 1'h0, `LPMSC_MODE_WATCH, 1'h0);
    step(1'h1, 8'h40, 1'h0, `LPMSC_MODE_WATCH, 1'h0);
    step(1'h1, 8'h40, 1'h1, `LPMSC_MODE_SUBACT, 1'h0);
    step(1'h0, 8'h40, 1'h0, `LPMSC_MODE_SUBSLP, 1'h0);
    step(1'h0, 8'h40, 1'h1, `LPMSC_MODE_SUBACT, 1'h0);
    step(1'h1, 8'h80, 1'h0, `LPMSC_MODE_HIGH, 1'h0);
    step(1'h1, 8'hC0, 1'h0, `LPMSC_MODE_SUBACT, 1'h0);
    step(1'h1, 8'h00, 1'h0, `LPMSC_MODE_WATCH, 1'h0);
    step(1'h1, 8'h00, 1'h1, `LPMSC_MODE_HIGH, 1'h0);
    // Cut setting must wait for a standby entry before it bites
    axi_wr(`LPMSC_OFF_LPC, 32'h08, `LPMSC_RESP_OKAY);
    @(posedge aclk);
    check(feedback_resistor_on, 1'h1);
    step(1'h1, 8'h08, 1'h0, `LPMSC_MODE_STBY, 1'h1);
    step(1'h1, 8'h08, 1'h1, `LPMSC_MODE_HIGH, 1'h1);
    step(1'h1, 8'h00, 1'h0, `LPMSC_MODE_STBY, 1'h0);
    step(1'h1, 8'h00, 1'h1, `LPMSC_MODE_HIGH, 1'h0);
    medium_speed_req <= 1'h1;
    for (n = 0; n < 20 && power_mode !== `LPMSC_MODE_MEDIUM; n++)
      @(posedge aclk);
    if (power_mode !== `LPMSC_MODE_MEDIUM) timed_out;
    check(power_mode, `LPMSC_MODE_MEDIUM);
    step(1'h0, 8'h00, 1'h0, `LPMSC_MODE_SLEEP, 1'h0);
    step(1'h0, 8'h00, 1'h1, `LPMSC_MODE_MEDIUM, 1'h0);
    // Medium speed cannot reach watch or subactive; standby is taken
    step(1'h1, 8'h40, 1'h0, `LPMSC_MODE_STBY, 1'h0);
    step(1'h1, 8'h40, 1'h1, `LPMSC_MODE_MEDIUM, 1'h0);
    // Status word: oscillator running, no cut applied, medium mode
    axi_wr(`LPMSC_OFF_MODE, 32'h0, `LPMSC_RESP_OKAY);
    rd_chk(`LPMSC_OFF_MODE, 32'h11, `LPMSC_RESP_OKAY);
    medium_speed_req <= 1'h0;
    $display("power mode test done");
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset;
    t_stops;
    t_lpc;
    t_modes;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
